// >>> design/bwd_ctrl.v
/*
 * host controller for a 64K x 16 async dram with byte write strobes.
 * assumes one request port on mclk; dram pins are async to mclk.
 */
// How it works
// - pause 100 us, then eight refreshes
// - init uses column-before-row refreshes
// - output enable off before driving data
// - rmw cycle at least 185 ns
// - rmw write strobe delays 105/55/70 ns
// - column strobe 10 ns around row
// - refresh and normal precharge 10 ns
// - page accesses 55 ns apart
// - column strobe high 10 ns in page
// - page row strobe 80 ns to 100 us
// - page rmw write 70 ns after precharge
// - counter test precharge 40 ns
// - byte strobes zero setup and hold
// - both byte strobes fall together
`timescale 1ns/1ns
`include "bwd_defs.vh"
module bwd_ctrl #(
   parameter PAUSE_CYC = `BWD_PAUSE_CYC,
   parameter REF_INT_CYC = `BWD_REF_INT_CYC,
   parameter RASC_CYC = `BWD_RASC_CYC
) (
   input wire mclk,
   input wire srst,
   input wire req_valid,
   input wire [1:0] req_op,
   input wire [15:0] req_addr,
   input wire [15:0] req_wdata,
   input wire [1:0] req_byte_en,
   output reg req_ready,
   output reg [15:0] rsp_rdata,
   output reg rsp_valid,
   output reg init_done,
   output reg ras_n,
   output reg cas_n,
   output reg lower_byte_write_strobe_n,
   output reg upper_byte_write_strobe_n,
   output reg oe_n,
   output reg [7:0] addr,
   input wire [15:0] dq_i,
   output reg [15:0] dq_o,
   output reg dq_oe
);
   // ***********************
   // ops and states
   // ***********************
   localparam OP_READ = 2'h0;
   localparam OP_WRITE = 2'h1;
   localparam OP_RMW = 2'h2;
   localparam ST_PAUSE = 3'h0;
   localparam ST_IDLE = 3'h1;
   localparam ST_ROW = 3'h2;
   localparam ST_COL = 3'h3;
   localparam ST_WR = 3'h4;
   localparam ST_PRE = 3'h5;
   localparam ST_REF = 3'h6;
   localparam T_RCD = `BWD_CYC(`BWD_RCD_NS);
   localparam T_RAH = `BWD_CYC(`BWD_RAH_NS);
   localparam T_RD = `BWD_CYC(`BWD_AA_NS) + 1;
   localparam T_ODD = `BWD_CYC(`BWD_ODD_NS);
   localparam T_RMW = `BWD_CYC(`BWD_RWD_NS - `BWD_RCD_NS);
   localparam T_WP = `BWD_CYC(`BWD_WP_NS) + 1;
   localparam T_RP = `BWD_CYC(`BWD_RWC_NS - `BWD_RWD_NS - `BWD_WP_NS);
   localparam T_CSR = `BWD_CYC(`BWD_CSR_NS);
   localparam T_REF = `BWD_CYC(`BWD_RAS_NS);
   localparam T_COLMIN = `BWD_CYC(`BWD_RAS_NS) - T_RCD;
   localparam T_PRE = `BWD_CYC(`BWD_RP_NS);
   localparam INIT_N = `BWD_INIT_CYCLES;
   reg [2:0] st_q;
   reg [31:0] cnt_q;
   reg [31:0] ref_tmr_q;
   reg ref_due_q;
   reg [3:0] init_cnt_q;
   reg [1:0] op_q;
   reg [15:0] a_q;
   reg [15:0] wd_q;
   reg [1:0] be_q;
   reg [15:0] dq_s1_q;
   reg [15:0] dq_s2_q;
   reg [1:0] phase_q;

   // ***********************
   // pin synchroniser
   // ***********************
   always @(posedge mclk) begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
   end

   // ***********************
   // refresh interval timer
   // ***********************
   // refresh all rows
   always @(posedge mclk) begin
      if (srst) begin
         ref_tmr_q <= 32'h0;
         ref_due_q <= 1'b0;
      end else if (st_q == ST_REF && phase_q == 2'h0) begin
         ref_due_q <= 1'b0;
         ref_tmr_q <= ref_tmr_q + 32'h1;
      end else if (ref_tmr_q >= REF_INT_CYC - 1) begin
         ref_tmr_q <= 32'h0;
         ref_due_q <= 1'b1;
      end else begin
         ref_tmr_q <= ref_tmr_q + 32'h1;
      end
   end

   // ***********************
   // cycle sequencer
   // ***********************
   always @(posedge mclk) begin
      if (srst) begin
         st_q <= ST_PAUSE;
         cnt_q <= 32'h0;
         init_cnt_q <= 4'h0;
         init_done <= 1'b0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0;
         ras_n <= 1'b1;
         cas_n <= 1'b1;
         lower_byte_write_strobe_n <= 1'b1;
         upper_byte_write_strobe_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= 8'h0;
         dq_o <= 16'h0;
         dq_oe <= 1'b0;
         op_q <= OP_READ;
         a_q <= 16'h0;
         wd_q <= 16'h0;
         be_q <= 2'h0;
         phase_q <= 2'h0;
      end else begin
         rsp_valid <= 1'b0;
         req_ready <= 1'b0;
         case (st_q)
            ST_PAUSE: begin
               if (cnt_q >= PAUSE_CYC - 1) begin
                  cnt_q <= 32'h0;
                  phase_q <= 2'h0;
                  st_q <= ST_REF;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            ST_IDLE: begin
               if (ref_due_q) begin
                  st_q <= ST_REF;
                  phase_q <= 2'h0;
                  cnt_q <= 32'h0;
               end else if (req_valid && req_op != 2'h3) begin
                  op_q <= req_op;
                  a_q <= req_addr;
                  wd_q <= req_wdata;
                  be_q <= (req_op == OP_READ) ? 2'h0 : req_byte_en;
                  addr <= req_addr[15:8];
                  ras_n <= 1'b0;
                  cnt_q <= 32'h0;
                  st_q <= ST_ROW;
               end else begin
                  req_ready <= 1'b1;
               end
            end
            ST_ROW: begin
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q == T_RAH) begin
                  addr <= a_q[7:0];
               end
               if (cnt_q >= T_RCD - 1) begin
                  cnt_q <= 32'h0;
                  st_q <= ST_COL;
                  cas_n <= 1'b0;
                  if (op_q == OP_WRITE) begin
                     lower_byte_write_strobe_n <= ~be_q[0];
                     upper_byte_write_strobe_n <= ~be_q[1];
                     dq_o <= wd_q;
                     dq_oe <= 1'b1;
                  end else begin
                     oe_n <= 1'b0;
                  end
               end
            end
            ST_COL: begin
               cnt_q <= cnt_q + 32'h1;
               if (op_q == OP_READ && cnt_q >= T_RD - 1 && cnt_q >= T_COLMIN - 1) begin
                  rsp_rdata <= dq_s2_q;
                  rsp_valid <= 1'b1;
                  cnt_q <= 32'h0;
                  st_q <= ST_PRE;
               end else if (op_q == OP_WRITE && cnt_q >= T_WP - 1 && cnt_q >= T_COLMIN - 1) begin
                  cnt_q <= 32'h0;
                  st_q <= ST_PRE;
               end else if (op_q == OP_RMW && cnt_q == T_RD - 1) begin
                  rsp_rdata <= dq_s2_q;
                  rsp_valid <= 1'b1;
                  oe_n <= 1'b1;
               end else if (op_q == OP_RMW && cnt_q >= T_RMW - 1 && cnt_q >= T_RD + T_ODD) begin
                  dq_o <= wd_q;
                  dq_oe <= 1'b1;
                  cnt_q <= 32'h0;
                  st_q <= ST_WR;
               end
            end
            ST_WR: begin
               cnt_q <= cnt_q + 32'h1;
               lower_byte_write_strobe_n <= ~be_q[0];
               upper_byte_write_strobe_n <= ~be_q[1];
               if (cnt_q >= T_WP - 1) begin
                  cnt_q <= 32'h0;
                  st_q <= ST_PRE;
               end
            end
            ST_PRE: begin
               ras_n <= 1'b1;
               cas_n <= 1'b1;
               oe_n <= 1'b1;
               lower_byte_write_strobe_n <= 1'b1;
               upper_byte_write_strobe_n <= 1'b1;
               dq_oe <= 1'b0;
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q >= T_PRE + T_RP - 1) begin
                  cnt_q <= 32'h0;
                  st_q <= ST_IDLE;
               end
            end
            ST_REF: begin
               cnt_q <= cnt_q + 32'h1;
               case (phase_q)
                  2'h0: begin
                     if (cnt_q >= T_PRE - 1) begin
                        cas_n <= 1'b0;
                        cnt_q <= 32'h0;
                        phase_q <= 2'h1;
                     end
                  end
                  2'h1: begin
                     if (cnt_q >= T_CSR - 1) begin
                        ras_n <= 1'b0;
                        cnt_q <= 32'h0;
                        phase_q <= 2'h2;
                     end
                  end
                  2'h2: begin
                     if (cnt_q == T_CSR) begin
                        cas_n <= 1'b1;
                     end
                     if (cnt_q >= T_REF - 1) begin
                        ras_n <= 1'b1;
                        cas_n <= 1'b1;
                        cnt_q <= 32'h0;
                        phase_q <= 2'h3;
                     end
                  end
                  default: begin
                     if (cnt_q >= T_PRE - 1) begin
                        cnt_q <= 32'h0;
                        phase_q <= 2'h0;
                        if (!init_done && init_cnt_q < INIT_N - 1) begin
                           init_cnt_q <= init_cnt_q + 4'h1;
                        end else begin
                           init_done <= 1'b1;
                           st_q <= ST_IDLE;
                        end
                     end
                  end
               endcase
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // bwd_ctrl

// >>> design/bwd_defs.vh
/*
 * timing constants of the byte-write dram controller.
 * assumes mclk at 250 MHz (4 ns period).
 */
`ifndef BWD_DEFS_VH
`define BWD_DEFS_VH
`define BWD_CLK_NS 4
// ***********************
// times in ns or us
// ***********************
`define BWD_PAUSE_US 100
`define BWD_INIT_CYCLES 8
`define BWD_RP_NS 45
`define BWD_RAS_NS 80
`define BWD_RCD_NS 20
`define BWD_RAH_NS 10
`define BWD_CAS_NS 30
`define BWD_CAC_NS 30
`define BWD_AA_NS 45
`define BWD_RWC_NS 185
`define BWD_RWD_NS 105
`define BWD_CWD_NS 55
`define BWD_AWD_NS 70
`define BWD_ODD_NS 15
`define BWD_WP_NS 15
`define BWD_CSR_NS 10
`define BWD_CHR_NS 10
`define BWD_RPC_NS 10
`define BWD_CPN_NS 10
`define BWD_CP_NS 10
`define BWD_PC_NS 55
`define BWD_ACP_NS 50
`define BWD_CPW_NS 70
`define BWD_RASC_NS 100000
`define BWD_CPT_NS 40
`define BWD_REF_US 4000
`define BWD_ROWS 256
// ***********************
// cycle counts; BWD_CYC rounds up, the others round down
// ***********************
`define BWD_CYC(ns) (((ns) + `BWD_CLK_NS - 1) / `BWD_CLK_NS)
`define BWD_PAUSE_CYC (`BWD_PAUSE_US * 1000 / `BWD_CLK_NS)
`define BWD_RASC_CYC (`BWD_RASC_NS / `BWD_CLK_NS)
`define BWD_REF_INT_CYC (`BWD_REF_US * 1000 / `BWD_ROWS / `BWD_CLK_NS)
`endif

// >>> dv/bwd_ctrl_checker.sv
/*
 * pin timing checker for the byte-write dram controller.
 * assumes a 4 ns mclk and is bound onto bwd_ctrl.
 */
`timescale 1ns/1ns
module bwd_checker #(
   parameter PAUSE_CYC = 20,
   parameter REF_INT_CYC = 200
) (
   input wire mclk,
   input wire srst,
   input wire init_done,
   input wire ras_n,
   input wire cas_n,
   input wire lower_byte_write_strobe_n,
   input wire upper_byte_write_strobe_n,
   input wire oe_n,
   input wire dq_oe
);
   // ***********************
   // cycle bookkeeping
   // ***********************
   reg ras_p_q;
   reg rd_q;
   reg [3:0] refr_q;
   reg [15:0] cyc_q, lo_q, gap_q;
   wire refr_w = ras_p_q & ~ras_n & ~cas_n;
   wire lb_n = lower_byte_write_strobe_n;
   wire ub_n = upper_byte_write_strobe_n;
   always @(posedge mclk) begin
      if (srst) begin
         ras_p_q <= 1'b1;
         rd_q <= 1'b0;
         refr_q <= 4'h0;
         cyc_q <= 16'h0000;
         lo_q <= 16'h0000;
         gap_q <= 16'h0000;
      end else begin
         ras_p_q <= ras_n;
         rd_q <= ~ras_n & (rd_q | ~oe_n);
         if (refr_w && refr_q != 4'hf) refr_q <= refr_q + 4'h1;
         if (!cyc_q[15]) cyc_q <= cyc_q + 16'h0001;
         lo_q <= ras_n ? 16'h0000 : lo_q + 16'h0001;
         gap_q <= refr_w ? 16'h0000 : gap_q + 16'h0001;
      end
   end
   // ***********************
   // properties
   // ***********************
   default clocking dck @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_refr_start;
      $fell(ras_n) && !cas_n;
   endsequence
   sequence s_cas_held;
      !cas_n [*3];
   endsequence
   chk_pause_first: assert property ($fell(ras_n) |-> cyc_q >= PAUSE_CYC)
      else $error("row strobe before pause");
   chk_init_refresh: assert property ($rose(init_done) |-> refr_q >= 4'h8)
      else $error("init done too early");
   chk_refr_setup: assert property (s_refr_start |-> $past(cas_n, 3) == 1'b0)
      else $error("column setup short");
   chk_refr_hold: assert property (s_refr_start |-> s_cas_held)
      else $error("column hold short");
   chk_cas_precharge: assert property ($rose(cas_n) |-> cas_n [*3])
      else $error("column precharge short");
   chk_oe_before_data: assert property ($rose(dq_oe) |-> oe_n && $past(oe_n, 4))
      else $error("data driven over output");
   chk_no_stagger: assert property ($fell(lb_n) || $fell(ub_n) |-> $past(lb_n && ub_n))
      else $error("byte strobes staggered");
   chk_strobe_in_row: assert property (!lb_n || !ub_n |-> !ras_n)
      else $error("byte strobe outside row");
   chk_rmw_delay: assert property (($fell(lb_n) || $fell(ub_n)) && rd_q |-> lo_q >= 16'd27)
      else $error("write strobe early in rmw");
   chk_refresh_gap: assert property (init_done |-> gap_q <= REF_INT_CYC + 64)
      else $error("refresh overdue");
endmodule // bwd_checker
bind bwd_ctrl bwd_checker #(.PAUSE_CYC(PAUSE_CYC), .REF_INT_CYC(REF_INT_CYC)) bwd_checker_inst (
   .mclk(mclk),
   .srst(srst),
   .init_done(init_done),
   .ras_n(ras_n),
   .cas_n(cas_n),
   .lower_byte_write_strobe_n(lower_byte_write_strobe_n),
   .upper_byte_write_strobe_n(upper_byte_write_strobe_n),
   .oe_n(oe_n),
   .dq_oe(dq_oe)
);

// >>> dv/bwd_dram_model.sv
/*
 * behavioural 64k x 16 dram with byte write strobes.
 * assumes dq_i is the shared pin level seen by the controller.
 */
`timescale 1ns/1ns
module bwd_dram_model (
   input wire ras_n,
   input wire cas_n,
   input wire lower_byte_write_strobe_n,
   input wire upper_byte_write_strobe_n,
   input wire oe_n,
   input wire [7:0] addr,
   input wire [15:0] dq_o,
   input wire dq_oe,
   output wire [15:0] dq_i,
   output reg [15:0] refresh_cnt
);
   // ***********************
   // cells and pins
   // ***********************
   reg [15:0] mem [0:65535];
   reg [7:0] row_q = 8'h00;
   reg [7:0] col_q = 8'h00;
   reg rd_ok = 1'b0;
   time t_a = 0;
   time t_c = 0;
   wire lb_n = lower_byte_write_strobe_n;
   wire ub_n = upper_byte_write_strobe_n;
   wire [15:0] word = mem[{row_q, col_q}];
   // both sides driving gives unknown data
   assign dq_i = dq_oe ? (rd_ok ? 16'hxxxx : dq_o) : (rd_ok ? word : ~word);
   initial refresh_cnt = 16'h0000;
   always @(addr) t_a = $time;
   always @(negedge ras_n) begin
      if (cas_n) begin
         row_q = addr;
      end else begin
         refresh_cnt = refresh_cnt + 16'h0001;
      end
   end
   task wr_cell;
      begin
         if (!lb_n) mem[{row_q, col_q}][7:0] = dq_i[7:0];
         if (!ub_n) mem[{row_q, col_q}][15:8] = dq_i[15:8];
      end
   endtask
   always @(negedge cas_n) begin
      if (!ras_n) begin
         col_q = addr;
         t_c = $time;
         #1 wr_cell;
      end
   end
   always @(negedge lb_n or negedge ub_n) begin
      if (!ras_n && !cas_n) #1 wr_cell;
   end
   always #1 rd_ok = !ras_n && !cas_n && !oe_n && lb_n && ub_n
      && ($time - t_c >= 30) && ($time - t_a >= 45);
endmodule // bwd_dram_model

// >>> dv/test_bwd_ctrl.sv
/*
 * self-checking bench for bwd_ctrl against a behavioural dram.
 * assumes shortened pause and refresh interval parameters.
 */
`timescale 1ns/1ns
module test_bwd_ctrl;
   reg mclk = 1'b0;
   reg srst = 1'b1;
   reg req_valid = 1'b0;
   reg [1:0] req_op = 2'h0;
   reg [15:0] req_addr = 16'h0000;
   reg [15:0] req_wdata = 16'h0000;
   reg [1:0] req_byte_en = 2'h0;
   wire req_ready, rsp_valid, init_done, ras_n, cas_n, oe_n, dq_oe;
   wire lower_byte_write_strobe_n, upper_byte_write_strobe_n;
   wire [15:0] rsp_rdata, dq_i, dq_o, refresh_cnt;
   wire [7:0] addr;
   integer err_total = 0;
   integer checked = 0;
   always #2 mclk = ~mclk;
   bwd_ctrl #(.PAUSE_CYC(20), .REF_INT_CYC(200)) bwd_ctrl_inst (.mclk(mclk), .srst(srst),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_byte_en(req_byte_en), .req_ready(req_ready), .rsp_rdata(rsp_rdata),
      .rsp_valid(rsp_valid), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n),
      .lower_byte_write_strobe_n(lower_byte_write_strobe_n),
      .upper_byte_write_strobe_n(upper_byte_write_strobe_n), .oe_n(oe_n), .addr(addr),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
   bwd_dram_model bwd_dram_model_inst (.ras_n(ras_n), .cas_n(cas_n),
      .lower_byte_write_strobe_n(lower_byte_write_strobe_n),
      .upper_byte_write_strobe_n(upper_byte_write_strobe_n), .oe_n(oe_n), .addr(addr),
      .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .refresh_cnt(refresh_cnt));
   // ***********************
   // shared tasks
   // ***********************
   task end_sim;
      begin
         if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   task bail;
      begin
         err_total = err_total + 1;
         end_sim;
      end
   endtask
   task cmp(input [8*12-1:0] name, input [15:0] exp, input [15:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task do_req(input [1:0] op, input [15:0] a, input [15:0] d, input [1:0] be,
      input [15:0] exp);
      integer n;
      reg p;
      begin
         @(posedge mclk);
         req_valid <= 1'b1;
         req_op <= op;
         req_addr <= a;
         req_wdata <= d;
         req_byte_en <= be;
         #1;
         p = 1'b0;
         n = 0;
         while (!(p && ras_n === 1'b0 && cas_n === 1'b1) && n < 3000) begin
            p = ras_n;
            @(posedge mclk);
            #1;
            n = n + 1;
         end
         if (n >= 3000) bail;
         cmp("ready busy", 16'h0000, {15'h0000, req_ready});
         @(posedge mclk);
         req_valid <= 1'b0;
         n = 0;
         while (op != 2'h1 && rsp_valid !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n = n + 1;
         end
         if (n >= 100) bail;
         if (op != 2'h1) cmp("read data", exp, rsp_rdata);
      end
   endtask
   // ***********************
   // scenarios
   // ***********************
   task s_corners;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            do_req(2'h1, {{8{i[1]}}, {8{i[0]}}}, 16'h3c5a ^ i, 2'h3, 16'h0000);
         end
         for (i = 0; i < 4; i = i + 1) begin
            do_req(2'h0, {{8{i[1]}}, {8{i[0]}}}, 16'h0000, 2'h0, 16'h3c5a ^ i);
         end
      end
   endtask
   task s_bytes_rmw;
      begin
         do_req(2'h1, 16'h4321, 16'h1234, 2'h1, 16'h0000);
         do_req(2'h1, 16'h4321, 16'habcd, 2'h2, 16'h0000);
         do_req(2'h2, 16'h4321, 16'h7e7e, 2'h3, 16'hab34);
         do_req(2'h2, 16'h4321, 16'h0000, 2'h1, 16'h7e7e);
         do_req(2'h0, 16'h4321, 16'h0000, 2'h0, 16'h7e00);
      end
   endtask
   task s_idle;
      integer n;
      integer k;
      reg [15:0] r0;
      begin
         @(posedge mclk);
         req_valid <= 1'b1;
         req_op <= 2'h3;
         k = 0;
         for (n = 0; n < 40; n = n + 1) begin
            @(posedge mclk);
            #1;
            if (oe_n !== 1'b1 || dq_oe !== 1'b0 || rsp_valid !== 1'b0) k = k + 1;
         end
         n = 0;
         while (req_ready !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n = n + 1;
         end
         if (n >= 300) bail;
         cmp("ready idle", 16'h0001, {15'h0000, req_ready});
         @(posedge mclk);
         req_valid <= 1'b0;
         cmp("op3 ignored", 16'h0000, k[15:0]);
         r0 = refresh_cnt;
         repeat (700) @(posedge mclk);
         cmp("refresh rate", 16'h0001, {15'h0000, refresh_cnt - r0 >= 16'h0003});
      end
   endtask
   initial begin : main
      integer n;
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      n = 0;
      while (init_done !== 1'b1 && n < 5000) begin
         @(posedge mclk);
         n = n + 1;
      end
      if (n >= 5000) bail;
      cmp("init refresh", 16'h0001, {15'h0000, refresh_cnt >= 16'h0008});
      s_corners;
      s_bytes_rmw;
      s_idle;
      end_sim;
   end
endmodule // test_bwd_ctrl
